// *** hw/dmms_pkg.sv ***
/*
 dmms_pkg: shared widths, constants, operand and mode carriers and helper
 functions of the dual multiply-subtract datapath.
 assumes: one core clock; operands read in the same cycle as the issue.
*/
package dmms_pkg;
   localparam int WORD_W = 16;
   localparam int EXT_W = 17;
   localparam int PROD_W = 32;
   localparam int ACC_W = 40;
   localparam int ADDR_W = 23;
   localparam logic [ADDR_W-1:0] COEF_STEP = 23'h000002;
   localparam logic [ADDR_W-1:0] AUX_STEP_SHARED = 23'h000001;
   localparam logic [ADDR_W-1:0] AUX_STEP_LONG = 23'h000002;
   localparam logic [ADDR_W-1:0] PTR_RESET = 23'h000000;
   localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;
   localparam logic [EXT_W-1:0] EXT_MIN = 17'h18000;
   localparam logic [PROD_W-1:0] PROD_SAT = 32'h7FFFFFFF;
   localparam logic [ACC_W:0] ROUND_ADD = 41'h00000008000;
   localparam logic [ACC_W:0] ROUND_KEEP = 41'h1FFFFFF0000;
   localparam logic [ACC_W:0] ROUND_LSB = 41'h00000010000;
   localparam logic [WORD_W-1:0] ROUND_TIE = 16'h8000;
   localparam logic [ACC_W-1:0] SAT32_POS = 40'h007FFFFFFF;
   localparam logic [ACC_W-1:0] SAT32_NEG = 40'hFF80000000;
   localparam logic [ACC_W-1:0] SAT40_POS = 40'h7FFFFFFFFF;
   localparam logic [ACC_W-1:0] SAT40_NEG = 40'h8000000000;
   localparam int OVF32_MSB = 40;
   localparam int OVF32_LSB = 31;

   typedef enum logic [0:0] {
      FORM_SHARED = 1'b0,
      FORM_LONG = 1'b1
   } dmms_form_t;

   typedef struct packed {
      logic fractionalShift;
      logic productSaturateSel;
      logic wideOverflowSel;
      logic roundingModeSel;
      logic accumSaturationEnable;
      logic signExtendSel;
   } dmms_mode_t;

   typedef struct packed {
      dmms_form_t form;
      logic roundEn;
      logic wide40;
      logic unsData;
      logic unsCoef;
      logic coefPostInc;
      logic auxPostDec;
   } dmms_opt_t;

   typedef struct packed {
      logic [WORD_W-1:0] dataReadBusPrimary;
      logic [WORD_W-1:0] dataReadBusSecondary;
      logic [WORD_W-1:0] coeffReadBusLow;
      logic [WORD_W-1:0] coeffReadBusHigh;
   } dmms_bus_t;

   // zero when unsigned option or sign mode off, else sign
   function automatic logic [EXT_W-1:0] extend17(input logic [WORD_W-1:0] w, input logic uns,
                                                input logic sxm);
      extend17 = {~uns & sxm & w[WORD_W-1], w};
   endfunction

   // flipping the lsb is +1 for even and -1 for odd
   function automatic logic [ADDR_W-1:0] pairAddr(input logic [ADDR_W-1:0] a);
      pairAddr = {a[ADDR_W-1:1], ~a[0]};
   endfunction
endpackage

// *** hw/dmms_mac_unit.sv ***
/*
 dmms_mac_unit: one combinational multiply-subtract lane: extension,
 product, fractional shift, product saturation, subtraction, rounding,
 overflow check and accumulator saturation.
 assumes: caller registers the result; operands stable for the cycle.
*/
`timescale 1ns/1ps
module dmms_mac_unit (
   input logic [dmms_pkg::WORD_W-1:0] opData, // data memory word
   input logic [dmms_pkg::WORD_W-1:0] opCoef, // coefficient word
   input logic unsData, // zero-extend data word
   input logic unsCoef, // zero-extend coefficient word
   input dmms_pkg::dmms_mode_t mode, // status mode bits
   input logic roundEn, // rounding option
   input logic wideEff, // effective 40-bit overflow
   input logic [dmms_pkg::ACC_W-1:0] accIn, // source accumulator
   output logic [dmms_pkg::ACC_W-1:0] accOut, // result to commit
   output logic ovf // accumulator overflow
);
   logic signed [dmms_pkg::EXT_W-1:0] extData;
   logic signed [dmms_pkg::EXT_W-1:0] extCoef;
   logic signed [33:0] rawProd;
   logic [dmms_pkg::PROD_W-1:0] shifted;
   logic prodSatHit;
   logic [dmms_pkg::PROD_W-1:0] prod;
   logic [dmms_pkg::ACC_W:0] diff;
   logic [dmms_pkg::ACC_W:0] roundSum;
   logic [dmms_pkg::ACC_W:0] rounded;
   logic [dmms_pkg::ACC_W:0] result;
   logic ovf40;
   logic ovf32;
   logic [dmms_pkg::ACC_W-1:0] satVal;

   assign extData = dmms_pkg::extend17(opData, unsData, mode.signExtendSel);
   assign extCoef = dmms_pkg::extend17(opCoef, unsCoef, mode.signExtendSel);
   assign rawProd = extData * extCoef;

   assign shifted = mode.fractionalShift ? {rawProd[30:0], 1'b0} : rawProd[31:0];

   // product overflow
   // with both operands sign-extended, only min times min can overflow once shifted, so one compare suffices
   assign prodSatHit = mode.fractionalShift & mode.productSaturateSel
                       & (extData == dmms_pkg::EXT_MIN) & (extCoef == dmms_pkg::EXT_MIN);
   assign prod = prodSatHit ? dmms_pkg::PROD_SAT : shifted;

   // extend and subtract
   // one guard bit keeps the 40-bit carry visible
   assign diff = {accIn[dmms_pkg::ACC_W-1], accIn} - {{9{prod[dmms_pkg::PROD_W-1]}}, prod};

   // rounding
   // mode set: exact half rounds to even by clearing the new lsb
   assign roundSum = (diff + dmms_pkg::ROUND_ADD) & dmms_pkg::ROUND_KEEP;
   assign rounded = !roundEn ? diff
                    : (mode.roundingModeSel && diff[15:0] == dmms_pkg::ROUND_TIE)
                    ? (roundSum & ~dmms_pkg::ROUND_LSB) : roundSum;

   assign ovf40 = rounded[dmms_pkg::ACC_W] ^ rounded[dmms_pkg::ACC_W-1];
   assign ovf32 = ~((&rounded[dmms_pkg::OVF32_MSB:dmms_pkg::OVF32_LSB])
                    | ~(|rounded[dmms_pkg::OVF32_MSB:dmms_pkg::OVF32_LSB]));
   assign ovf = wideEff ? ovf40 : ovf32;

   assign satVal = rounded[dmms_pkg::ACC_W]
                   ? (wideEff ? dmms_pkg::SAT40_NEG : dmms_pkg::SAT32_NEG)
                   : (wideEff ? dmms_pkg::SAT40_POS : dmms_pkg::SAT32_POS);
   assign result = rounded;
   assign accOut = (ovf & mode.accumSaturationEnable) ? satVal : result[dmms_pkg::ACC_W-1:0];
endmodule

// *** hw/dmms_datapath.sv ***
/*
 dmms_datapath: dual multiply-subtract datapath. Holds both accumulators,
 their overflow flags and the coefficient and aux pointers; drives the
 operand addresses and commits both lanes in the issue cycle.
 assumes: memory answers the driven addresses combinationally in the same
 cycle; all inputs come from logic on clk_sys.
*/
`timescale 1ns/1ps
module dmms_datapath (
   input logic clk_sys, // core clock
   input logic nrst, // async reset, active low
   input logic ce, // clock enable, freezes state
   input logic issue, // execute one instruction
   input dmms_pkg::dmms_opt_t opts, // instruction options
   input dmms_pkg::dmms_mode_t mode, // status mode bits
   input dmms_pkg::dmms_bus_t buses, // read buses
   input logic accLoadX, // load accum_x
   input logic accLoadY, // load accum_y
   input logic [dmms_pkg::ACC_W-1:0] accLoadValue, // load value
   input logic ovfClearX, // clear accum_x flag
   input logic ovfClearY, // clear accum_y flag
   input logic ptrLoad, // load both pointers
   input logic [dmms_pkg::ADDR_W-1:0] ptrLoadCoef, // coefficient pointer value
   input logic [dmms_pkg::ADDR_W-1:0] ptrLoadAux, // aux pointer value
   output logic [dmms_pkg::ADDR_W-1:0] dataAddrHigh, // data path X, effective
   output logic [dmms_pkg::ADDR_W-1:0] dataAddrLow, // data path X, paired
   output logic [dmms_pkg::ADDR_W-1:0] coeffAddrHigh, // coeff address bus, effective
   output logic [dmms_pkg::ADDR_W-1:0] coeffAddrLow, // coeff address bus, paired
   output logic [dmms_pkg::ACC_W-1:0] accumX, // accumulator x
   output logic [dmms_pkg::ACC_W-1:0] accumY, // accumulator y
   output logic accumXOverflowFlag, // sticky overflow x
   output logic accumYOverflowFlag, // sticky overflow y
   output logic [dmms_pkg::ADDR_W-1:0] coefficientPointer, // coefficient pointer
   output logic [dmms_pkg::ADDR_W-1:0] auxPointer, // aux pointer
   output logic doneStrobe // one-cycle commit pulse
);
   logic fire;
   logic wideEff;
   logic [dmms_pkg::WORD_W-1:0] unitOneData;
   logic [dmms_pkg::WORD_W-1:0] unitTwoData;
   logic [dmms_pkg::WORD_W-1:0] unitOneCoef;
   logic [dmms_pkg::WORD_W-1:0] unitTwoCoef;
   logic [dmms_pkg::ACC_W-1:0] unitOneAcc;
   logic [dmms_pkg::ACC_W-1:0] unitTwoAcc;
   logic unitOneOvf;
   logic unitTwoOvf;
   logic [dmms_pkg::ADDR_W-1:0] auxStep;
   logic [dmms_pkg::ACC_W-1:0] next_accumX;
   logic [dmms_pkg::ACC_W-1:0] next_accumY;
   logic next_flagX;
   logic next_flagY;
   logic [dmms_pkg::ADDR_W-1:0] next_coef;
   logic [dmms_pkg::ADDR_W-1:0] next_aux;

   assign fire = ce & issue;

   // local wide override, stored bit untouched
   assign wideEff = mode.wideOverflowSel | opts.wide40;

   assign coeffAddrHigh = coefficientPointer;
   assign dataAddrHigh = auxPointer;

   // paired addresses
   // coefficients must sit in internal memory, no external path exists
   assign coeffAddrLow = dmms_pkg::pairAddr(coefficientPointer);
   assign dataAddrLow = dmms_pkg::pairAddr(auxPointer);

   // data operand routing
   // unit one always takes the primary bus: shared word or low half
   assign unitOneData = buses.dataReadBusPrimary;
   assign unitTwoData = (opts.form == dmms_pkg::FORM_LONG)
                        ? buses.dataReadBusSecondary : buses.dataReadBusPrimary;

   assign unitOneCoef = buses.coeffReadBusLow;
   assign unitTwoCoef = buses.coeffReadBusHigh;

   // lane one writes accum_x
   dmms_mac_unit u_unit_one (
      .opData(unitOneData),
      .opCoef(unitOneCoef),
      .unsData(opts.unsData),
      .unsCoef(opts.unsCoef),
      .mode(mode),
      .roundEn(opts.roundEn),
      .wideEff(wideEff),
      .accIn(accumX),
      .accOut(unitOneAcc),
      .ovf(unitOneOvf)
   );

   // lane two writes accum_y
   dmms_mac_unit u_unit_two (
      .opData(unitTwoData),
      .opCoef(unitTwoCoef),
      .unsData(opts.unsData),
      .unsCoef(opts.unsCoef),
      .mode(mode),
      .roundEn(opts.roundEn),
      .wideEff(wideEff),
      .accIn(accumY),
      .accOut(unitTwoAcc),
      .ovf(unitTwoOvf)
   );

   // both lanes read old values only
   // issue outranks a load in the same cycle
   assign next_accumX = issue ? unitOneAcc : (accLoadX ? accLoadValue : accumX);
   assign next_accumY = issue ? unitTwoAcc : (accLoadY ? accLoadValue : accumY);

   assign next_flagX = (issue & unitOneOvf) | (accumXOverflowFlag & ~ovfClearX);
   assign next_flagY = (issue & unitTwoOvf) | (accumYOverflowFlag & ~ovfClearY);

   assign auxStep = (opts.form == dmms_pkg::FORM_LONG)
                    ? dmms_pkg::AUX_STEP_LONG : dmms_pkg::AUX_STEP_SHARED;
   assign next_coef = ptrLoad ? ptrLoadCoef
                      : (issue & opts.coefPostInc) ? coefficientPointer + dmms_pkg::COEF_STEP
                      : coefficientPointer;
   assign next_aux = ptrLoad ? ptrLoadAux
                     : (issue & opts.auxPostDec) ? auxPointer - auxStep
                     : auxPointer;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         accumX <= dmms_pkg::ACC_RESET;
         accumY <= dmms_pkg::ACC_RESET;
         accumXOverflowFlag <= 1'b0;
         accumYOverflowFlag <= 1'b0;
      end
      else if (ce)
      begin
         accumX <= next_accumX;
         accumY <= next_accumY;
         accumXOverflowFlag <= next_flagX;
         accumYOverflowFlag <= next_flagY;
      end
   end

   // pointers and commit pulse
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         coefficientPointer <= dmms_pkg::PTR_RESET;
         auxPointer <= dmms_pkg::PTR_RESET;
         doneStrobe <= 1'b0;
      end
      else if (ce)
      begin
         coefficientPointer <= next_coef;
         auxPointer <= next_aux;
         doneStrobe <= issue;
      end
   end

   // shared operand reaches both lanes
   AST_SHARED_OPERAND:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && opts.form == dmms_pkg::FORM_SHARED
         |-> unitOneData == buses.dataReadBusPrimary && unitTwoData == buses.dataReadBusPrimary)
      else $error("shared operand not on both lanes");

   // high coefficient at the effective address
   AST_COEF_HIGH:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire |-> coeffAddrHigh == coefficientPointer && unitTwoCoef == buses.coeffReadBusHigh)
      else $error("high coefficient path wrong");

   // low coefficient at the paired address
   AST_COEF_LOW:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire |-> unitOneCoef == buses.coeffReadBusLow
                  && coeffAddrLow == (coefficientPointer[0] ? coefficientPointer - 23'h000001
                                                              : coefficientPointer + 23'h000001))
      else $error("low coefficient path wrong");

   // long form high half from secondary bus
   AST_LONG_HIGH:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && opts.form == dmms_pkg::FORM_LONG
         |-> unitTwoData == buses.dataReadBusSecondary && dataAddrHigh == auxPointer)
      else $error("long high half path wrong");

   // paired address arithmetic
   AST_PAIR_ADDR:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         auxPointer[0] ? (dataAddrLow == auxPointer - 23'h000001)
                       : (dataAddrLow == auxPointer + 23'h000001))
      else $error("paired address wrong");

   // commit pulse the edge after issue
   AST_ONE_CYCLE:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire |=> doneStrobe ##1 (!doneStrobe || $past(issue)))
      else $error("commit not single cycle");

   // flag follows lane overflow
   AST_OVF_FLAG:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && unitTwoOvf |=> accumYOverflowFlag ##1 (accumYOverflowFlag || $past(ovfClearY)))
      else $error("overflow flag y not set");

   // saturated 32-bit value on overflow
   AST_SAT32:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && unitOneOvf && mode.accumSaturationEnable && !wideEff
         |=> accumX == dmms_pkg::SAT32_POS || accumX == dmms_pkg::SAT32_NEG)
      else $error("accum x not saturated");

   // 40-bit option widens saturation
   AST_WIDE_OPT:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && opts.wide40 && unitTwoOvf && mode.accumSaturationEnable
         |=> accumY == dmms_pkg::SAT40_POS || accumY == dmms_pkg::SAT40_NEG)
      else $error("40-bit option ignored");

   // coefficient pointer steps by two
   AST_COEF_STEP:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && !ptrLoad && opts.coefPostInc
         |=> coefficientPointer == $past(coefficientPointer) + 23'h000002)
      else $error("coefficient pointer step wrong");

   // aux pointer steps once by one
   AST_AUX_STEP:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire && !ptrLoad && opts.auxPostDec && opts.form == dmms_pkg::FORM_SHARED
         |=> auxPointer == $past(auxPointer) - 23'h000001)
      else $error("aux pointer step wrong");

   // both lanes commit together
   AST_COMMIT:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         fire |=> accumX == $past(unitOneAcc) && accumY == $past(unitTwoAcc))
      else $error("lanes not committed together");

   // frozen state while enable is low
   AST_FREEZE:
      assert property (@(posedge clk_sys) disable iff (!nrst)
         !ce |=> $stable(accumX) && $stable(accumY) && $stable(auxPointer))
      else $error("state moved with enable low");
endmodule

// *** verification/dmms_mem_model.sv ***
/*
 dmms_mem_model: data and coefficient memory seen by the dual
 multiply-subtract datapath, answering its four operand addresses.
 assumes: reads answer combinationally in the cycle the address is driven.
*/
`timescale 1ns/1ps
module dmms_mem_model (
   input wire logic [dmms_pkg::ADDR_W-1:0] dataAddrHigh, // effective data address
   input wire logic [dmms_pkg::ADDR_W-1:0] dataAddrLow, // paired data address
   input wire logic [dmms_pkg::ADDR_W-1:0] coeffAddrHigh, // effective coefficient address
   input wire logic [dmms_pkg::ADDR_W-1:0] coeffAddrLow, // paired coefficient address
   input wire dmms_pkg::dmms_form_t form, // operand form this cycle
   output dmms_pkg::dmms_bus_t buses // read buses
);
   // only 64 words each, so addresses alias on the low six bits
   logic [15:0] dataMem [0:63];
   logic [15:0] coefMem [0:63];
   logic [15:0] sharedWord;
   logic [15:0] lowWord;
   assign sharedWord = dataMem[dataAddrHigh[5:0]];
   assign lowWord = dataMem[dataAddrLow[5:0]];
   // data buses by form; the idle bus shows the inverse, never a stale copy
   assign buses = (form == dmms_pkg::FORM_LONG) ?
      {lowWord, sharedWord, coefMem[coeffAddrLow[5:0]], coefMem[coeffAddrHigh[5:0]]} :
      {sharedWord, ~sharedWord, coefMem[coeffAddrLow[5:0]], coefMem[coeffAddrHigh[5:0]]};
endmodule

// *** verification/test_dual_mac_parallel_multiply_subtract.sv ***
/*
 test_dual_mac_parallel_multiply_subtract: directed bench for the dual
 multiply-subtract datapath with its own lane reference and state shadow.
 assumes: dmms_mem_model answers the operand reads in the same cycle.
*/
`timescale 1ns/1ps
module test_dual_mac_parallel_multiply_subtract;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic issue = 1'b0;
   dmms_pkg::dmms_opt_t opts = '0;
   dmms_pkg::dmms_mode_t mode = '0;
   dmms_pkg::dmms_bus_t buses;
   logic accLoadX = 1'b0;
   logic accLoadY = 1'b0;
   logic [39:0] accLoadValue = 40'h0000000000;
   logic ovfClearX = 1'b0;
   logic ovfClearY = 1'b0;
   logic ptrLoad = 1'b0;
   logic [22:0] ptrLoadCoef = 23'h000000;
   logic [22:0] ptrLoadAux = 23'h000000;
   logic [22:0] dataAddrHigh, dataAddrLow, coeffAddrHigh, coeffAddrLow, coefficientPointer, auxPointer, sCoef, sAux;
   logic [39:0] accumX, accumY, sAccX, sAccY;
   logic accumXOverflowFlag, accumYOverflowFlag, doneStrobe, sFlagX, sFlagY;
   int failures = 0;
   int checked = 0;

   // 250 MHz core clock
   always #2 clk_sys = ~clk_sys;

   dmms_datapath DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .issue(issue), .opts(opts), .mode(mode),
      .buses(buses), .accLoadX(accLoadX), .accLoadY(accLoadY), .accLoadValue(accLoadValue),
      .ovfClearX(ovfClearX), .ovfClearY(ovfClearY), .ptrLoad(ptrLoad), .ptrLoadCoef(ptrLoadCoef),
      .ptrLoadAux(ptrLoadAux), .dataAddrHigh(dataAddrHigh), .dataAddrLow(dataAddrLow),
      .coeffAddrHigh(coeffAddrHigh), .coeffAddrLow(coeffAddrLow), .accumX(accumX), .accumY(accumY),
      .accumXOverflowFlag(accumXOverflowFlag), .accumYOverflowFlag(accumYOverflowFlag),
      .coefficientPointer(coefficientPointer), .auxPointer(auxPointer), .doneStrobe(doneStrobe));

   dmms_mem_model mem (.dataAddrHigh(dataAddrHigh), .dataAddrLow(dataAddrLow), .coeffAddrHigh(coeffAddrHigh),
      .coeffAddrLow(coeffAddrLow), .form(opts.form), .buses(buses));

   // inputs move 1 ns after the edge so the sampling edge never races them
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [22:0] pairOf(input logic [22:0] a);
      return a[0] ? a - 23'h000001 : a + 23'h000001;
   endfunction

   // one lane, worked out independently: {overflow, result}
   function automatic logic [40:0] lane(input logic [15:0] w, input logic [15:0] c, input logic uw,
         input logic uc, input logic [39:0] acc);
      logic [16:0] ew;
      logic [16:0] ec;
      logic [33:0] pr;
      logic [31:0] p;
      logic [40:0] d;
      logic [15:0] low;
      logic wide;
      logic ov;
      ew = {~uw & mode.signExtendSel & w[15], w};
      ec = {~uc & mode.signExtendSel & c[15], c};
      pr = $signed(ew) * $signed(ec);
      p = mode.fractionalShift ? {pr[30:0], 1'b0} : pr[31:0];
      if (mode.fractionalShift && mode.productSaturateSel && ew == 17'h18000 && ec == 17'h18000)
         p = 32'h7FFFFFFF;
      d = {acc[39], acc} - {{9{p[31]}}, p};
      low = d[15:0];
      if (opts.roundEn)
      begin
         d = d + 41'h00000008000;
         d[15:0] = 16'h0000;
         if (mode.roundingModeSel && low == 16'h8000)
            d[16] = 1'b0;
      end
      wide = mode.wideOverflowSel | opts.wide40;
      ov = wide ? (d[40] != d[39]) : !(&d[40:31] || ~|d[40:31]);
      if (ov && mode.accumSaturationEnable)
         d[39:0] = wide ? (d[40] ? 40'h8000000000 : 40'h7FFFFFFFFF) : (d[40] ? 40'hFF80000000 : 40'h007FFFFFFF);
      return {ov, d[39:0]};
   endfunction

   task automatic check_state(input logic done);
      check("accumX", accumX, sAccX);
      check("accumY", accumY, sAccY);
      check("flagX", accumXOverflowFlag, sFlagX);
      check("flagY", accumYOverflowFlag, sFlagY);
      check("coefPtr", coefficientPointer, sCoef);
      check("auxPtr", auxPointer, sAux);
      check("doneStrobe", doneStrobe, done);
   endtask

   task automatic set_case(input logic [39:0] acc, input logic [22:0] aux, input logic [22:0] coef);
      ptrLoad = 1'b1;
      ptrLoadAux = aux;
      ptrLoadCoef = coef;
      accLoadX = 1'b1;
      accLoadY = 1'b1;
      accLoadValue = acc;
      ovfClearX = 1'b1;
      ovfClearY = 1'b1;
      tick();
      ptrLoad = 1'b0;
      accLoadX = 1'b0;
      accLoadY = 1'b0;
      ovfClearX = 1'b0;
      ovfClearY = 1'b0;
      sAccX = acc;
      sAccY = acc;
      sFlagX = 1'b0;
      sFlagY = 1'b0;
      sAux = aux;
      sCoef = coef;
      check_state(1'b0);
   endtask

   // n back-to-back issues, each judged against the shadow
   task automatic run_op(input int n);
      logic [40:0] rx;
      logic [40:0] ry;
      logic [15:0] dx;
      logic [15:0] dy;
      logic [22:0] pd;
      logic [22:0] pc;
      for (int i = 0; i < n; i++)
      begin
         pd = pairOf(sAux);
         pc = pairOf(sCoef);
         check("dataAddrHigh", dataAddrHigh, sAux);
         check("dataAddrLow", dataAddrLow, pd);
         check("coeffAddrHigh", coeffAddrHigh, sCoef);
         check("coeffAddrLow", coeffAddrLow, pc);
         dy = mem.dataMem[sAux[5:0]];
         dx = (opts.form == dmms_pkg::FORM_LONG) ? mem.dataMem[pd[5:0]] : dy;
         rx = lane(dx, mem.coefMem[pc[5:0]], opts.unsData, opts.unsCoef, sAccX);
         ry = lane(dy, mem.coefMem[sCoef[5:0]], opts.unsData, opts.unsCoef, sAccY);
         issue = 1'b1;
         tick();
         sAccX = rx[39:0];
         sAccY = ry[39:0];
         sFlagX = sFlagX | rx[40];
         sFlagY = sFlagY | ry[40];
         if (opts.coefPostInc)
            sCoef = sCoef + 23'h000002;
         if (opts.auxPostDec)
            sAux = sAux - ((opts.form == dmms_pkg::FORM_LONG) ? 23'h000002 : 23'h000001);
         check_state(1'b1);
      end
      // a pending load drops with issue so it cannot land on the idle edge
      issue = 1'b0;
      accLoadX = 1'b0;
      tick();
      check_state(1'b0);
   endtask

   task automatic tcase(input logic [6:0] o, input logic [5:0] m, input logic [39:0] acc, input logic [15:0] d0,
         input logic [15:0] d1, input logic [15:0] c0, input logic [15:0] c1, input int n);
      opts = dmms_pkg::dmms_opt_t'(o);
      mode = dmms_pkg::dmms_mode_t'(m);
      mem.dataMem[6'h10] = d0;
      mem.dataMem[6'h11] = d1;
      mem.coefMem[6'h21] = c0;
      mem.coefMem[6'h20] = c1;
      // odd coefficient pointer so its pair lies below it
      set_case(acc, 23'h000010, 23'h000021);
      run_op(n);
      $display("case opts %h mode %h done", o, m);
   endtask

   task automatic t_reset;
      sAccX = 40'h0000000000;
      sAccY = 40'h0000000000;
      sFlagX = 1'b0;
      sFlagY = 1'b0;
      sCoef = 23'h000000;
      sAux = 23'h000000;
      check_state(1'b0);
      check("lowAddr", dataAddrLow, 23'h000001);
      $display("reset test done");
   endtask

   // worked long-form unsigned case with known figures
   task automatic t_example;
      opts = dmms_pkg::dmms_opt_t'(7'h4F);
      mode = dmms_pkg::dmms_mode_t'(6'h00);
      mem.dataMem[6'h3E] = 16'hFF00;
      mem.dataMem[6'h3F] = 16'hFE00;
      mem.coefMem[6'h00] = 16'h8000;
      mem.coefMem[6'h01] = 16'h4000;
      set_case(40'h0000008000, 23'h0010FE, 23'h002000);
      run_op(1);
      check("exampleX", accumX, 40'hFFC0808000);
      check("exampleY", accumY, 40'hFF80808000);
      check("exampleAux", auxPointer, 23'h0010FC);
      check("exampleCoef", coefficientPointer, 23'h002002);
      $display("example test done");
   endtask

   // frozen clock enable, then an accumulator load that an issue overrides
   task automatic t_hold;
      ce = 1'b0;
      issue = 1'b1;
      accLoadX = 1'b1;
      accLoadValue = 40'h1111111111;
      tick();
      tick();
      check_state(1'b0);
      ce = 1'b1;
      run_op(1);
      accLoadX = 1'b0;
      $display("hold test done");
   endtask

   task automatic stop_test;
      $display("Counts: checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // watchdog well beyond the 49 cycles of the run
   initial
   begin
      #20000;
      failures++;
      stop_test();
   end

   initial
   begin
      for (int i = 0; i < 64; i++)
      begin
         mem.dataMem[i] = 16'h1357 ^ (16'h0111 * i[15:0]);
         mem.coefMem[i] = 16'h2468 ^ (16'h0203 * i[15:0]);
      end
      repeat (3) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      t_reset();
      t_example();
      tcase(7'h03, 6'h01, 40'h0000001234, 16'h8123, 16'h5555, 16'h7FFF, 16'h9000, 3);
      // fractional with and without product saturation, both rounding modes, then overflow with and without saturation
      tcase(7'h00, 6'h31, 40'h0000000000, 16'h8000, 16'h0000, 16'h8000, 16'h8000, 1);
      tcase(7'h00, 6'h21, 40'h0000000000, 16'h8000, 16'h0000, 16'h8000, 16'h8000, 1);
      tcase(7'h20, 6'h01, 40'h0000028000, 16'h0000, 16'h0000, 16'h1234, 16'h4321, 1);
      tcase(7'h20, 6'h05, 40'h0000028000, 16'h0000, 16'h0000, 16'h1234, 16'h4321, 1);
      tcase(7'h10, 6'h03, 40'h007FFFFFFF, 16'h8000, 16'h0000, 16'h7FFF, 16'h7FFF, 1);
      tcase(7'h00, 6'h03, 40'h007FFFFFFF, 16'h8000, 16'h0000, 16'h7FFF, 16'h7FFF, 1);
      tcase(7'h00, 6'h0B, 40'h007FFFFFFF, 16'h8000, 16'h0000, 16'h7FFF, 16'h7FFF, 1);
      tcase(7'h00, 6'h01, 40'h007FFFFFFF, 16'h8000, 16'h0000, 16'h7FFF, 16'h7FFF, 1);
      tcase(7'h10, 6'h02, 40'h7FFFFFFFFF, 16'h8000, 16'h0000, 16'h7FFF, 16'h7FFF, 1);
      // long form, sign mode off and per-operand zero extension
      tcase(7'h41, 6'h00, 40'h0000000001, 16'hFF00, 16'h8001, 16'h8000, 16'hFFFF, 2);
      tcase(7'h48, 6'h01, 40'h0000000000, 16'h8000, 16'hFFFF, 16'hFFFF, 16'h8000, 1);
      t_hold();
      stop_test();
   end
endmodule
